// File: rtl/ccv_regs.svh
// Register offsets, field positions, reset values and ratio codes.
`ifndef CCV_REGS_SVH
`define CCV_REGS_SVH

`define CCV_ADDR_W            7
`define CCV_DATA_W            9
`define CCV_OFS_ATTEN_L1      7'h00
`define CCV_OFS_ATTEN_R1      7'h01
`define CCV_OFS_ATTEN_L2      7'h04
`define CCV_OFS_ATTEN_R2      7'h05
`define CCV_OFS_ATTEN_L3      7'h06
`define CCV_OFS_ATTEN_R3      7'h07
`define CCV_OFS_ATTEN_ALL     7'h08
`define CCV_OFS_ZERO_FLAG     7'h09
`define CCV_OFS_IFACE_PWR     7'h0A
`define CCV_OFS_ADC_OSR       7'h0B
`define CCV_OFS_ADC_CTRL      7'h0C
`define CCV_OFS_SOFT_RESET    7'h1F

`define CCV_BIT_UPDATE        8
`define CCV_BIT_POWERDOWN     4
`define CCV_BIT_ROLE          5
`define CCV_RATE_MSB          8
`define CCV_RATE_LSB          6
`define CCV_BIT_OSR           8
`define CCV_BIT_HPD           3
`define CCV_BIT_MPD           6
`define CCV_ZFS_MSB           2
`define CCV_ZFS_LSB           1

`define CCV_RST_ATTEN         8'hFF
`define CCV_RST_RATE          3'h2
`define CCV_RST_ZFS           2'h0

`define CCV_RATE_128          3'h0
`define CCV_RATE_192          3'h1
`define CCV_RATE_256          3'h2
`define CCV_RATE_384          3'h3
`define CCV_RATE_512          3'h4
`define CCV_RATE_768          3'h5

`define CCV_BCLK_PER_FRAME    64

`endif

// File: rtl/ccv_pkg.sv
// Types shared by the codec control register bank.
package ccv_pkg;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [8:0] data;
  } ccv_wr_t;

  typedef struct packed {
    logic [5:0][7:0] chan;
    logic [7:0]      global;
  } ccv_atten_t;

  typedef struct packed {
    logic in;
    logic out;
    logic oe_n;
  } ccv_pin_t;

endpackage : ccv_pkg

// File: rtl/ccv_clkgen.sv
// Frame and bit clock generator for master role, divided from clk.
`timescale 1ns/100ps
`include "ccv_regs.svh"

module ccv_clkgen
  import ccv_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] rate,
  output logic            frame_clock,
  output logic            bit_clock
);

  logic [9:0] frame_len;
  logic [3:0] bit_len;
  logic [9:0] mclk_cnt_reg;
  logic [3:0] bit_cnt_reg;

  // Undefined ratio codes fall back to the reset ratio.
  always_comb
  begin
    unique case (rate)
      `CCV_RATE_128: frame_len = 10'd128;
      `CCV_RATE_192: frame_len = 10'd192;
      `CCV_RATE_384: frame_len = 10'd384;
      `CCV_RATE_512: frame_len = 10'd512;
      `CCV_RATE_768: frame_len = 10'd768;
      default:       frame_len = 10'd256;
    endcase
    bit_len = 4'(frame_len / 10'(`CCV_BCLK_PER_FRAME));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      mclk_cnt_reg <= 10'h000;
      bit_cnt_reg  <= 4'h0;
    end
    else
    begin
      mclk_cnt_reg <= (mclk_cnt_reg >= frame_len - 10'd1) ? 10'h000
                      : mclk_cnt_reg + 10'd1;
      bit_cnt_reg  <= (bit_cnt_reg >= bit_len - 4'd1 ||
                       mclk_cnt_reg >= frame_len - 10'd1) ? 4'h0
                      : bit_cnt_reg + 4'd1;
    end
  end

  // Both clocks start low so the first frame edge is clean.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      frame_clock <= 1'b0;
      bit_clock   <= 1'b0;
    end
    else
    begin
      frame_clock <= mclk_cnt_reg < (frame_len >> 1);
      bit_clock   <= bit_cnt_reg >= (bit_len >> 1);
    end
  end

endmodule : ccv_clkgen

// File: rtl/ccv_ctrl.sv
// Control register bank: power, interface role, ADC setup, mutes, volume.
`timescale 1ns/100ps
`include "ccv_regs.svh"

// Notes on behaviour
// - Master powerdown bit turns off all references; clearing it restores.
// - Role bit 1 drives frame and bit clocks; 0 takes them as inputs.
// - Master role derives both clocks from clk using the ratio field.
// - Ratio codes 000..101 give 128,192,256,384,512,768 fs.
// - Oversample bit set selects 64x, clear selects 128x; default clear.
// - 64x only applies at 256fs or 384fs; otherwise 128x.
// - Highpass active by default; disable bit 3 bypasses it.
// - Mute pin input with decoding soft-mutes the selected channel.
// - Mute pin output reports the zero flag of the selected channel.
// - Default selection 00 covers all six DACs for mute and zero report.
// - Decode disabled: any high on the mute pin mutes every DAC.
// - Six per-channel eight-bit attenuations, reset to FF meaning 0dB.
// - A global eight-bit attenuation for all channels, reset to FF.
// - Code 00 mutes, 01 is -127dB, FE is -0.5dB, FF is 0dB.
// - Attenuation write with bit 8 clear fills only the pending latch.
// - Attenuation write with bit 8 set moves all latches to active.
// - Write to address 11111 returns every register to default.
// - After software reset, hold reset state until the next write.
// - Zero select 00 all channels, 01 ch1, 10 ch2, 11 ch3.
module ccv_ctrl
  import ccv_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire ccv_pkg::ccv_wr_t    wr,
  input  wire logic                mute_pin_is_input,
  input  wire logic [5:0]          dac_zero_flag,
  input  wire logic                mute_pin_in,
  output logic                     mute_pin_out,
  output logic                     mute_pin_oe_n,
  input  wire logic                frame_clock_in,
  output logic                     frame_clock_out,
  output logic                     frame_clock_oe_n,
  input  wire logic                bit_clock_in,
  output logic                     bit_clock_out,
  output logic                     bit_clock_oe_n,
  output logic                     frame_clock_seen,
  output logic                     bit_clock_seen,
  output logic                     ref_powerdown,
  output logic                     adc_osr_64x,
  output logic                     adc_highpass_bypass,
  output logic [5:0]               dac_soft_mute,
  output ccv_pkg::ccv_atten_t      atten_active,
  output logic                     soft_reset_hold
);
  import ccv_pkg::*;

  localparam int N_ATT = 7;

  // Pending latch index per attenuation address; N_ATT means not one.
  function automatic logic [2:0] atten_index(input logic [6:0] addr);
    logic [2:0] idx;
    idx = 3'(N_ATT);
    unique case (addr)
      `CCV_OFS_ATTEN_L1:  idx = 3'd0;
      `CCV_OFS_ATTEN_R1:  idx = 3'd1;
      `CCV_OFS_ATTEN_L2:  idx = 3'd2;
      `CCV_OFS_ATTEN_R2:  idx = 3'd3;
      `CCV_OFS_ATTEN_L3:  idx = 3'd4;
      `CCV_OFS_ATTEN_R3:  idx = 3'd5;
      `CCV_OFS_ATTEN_ALL: idx = 3'd6;
      default:            idx = 3'(N_ATT);
    endcase
    return idx;
  endfunction : atten_index

  // Channel mask chosen by the zero-flag select code.
  function automatic logic [5:0] zfs_mask(input logic [1:0] sel);
    logic [5:0] m;
    unique case (sel)
      2'h0: m = 6'h3F;
      2'h1: m = 6'h03;
      2'h2: m = 6'h0C;
      2'h3: m = 6'h30;
    endcase
    return m;
  endfunction : zfs_mask

  logic             wr_sreset;
  logic             wr_regular;
  logic [2:0]       wr_idx;
  logic             wr_update;
  logic [7:0]       pending_reg [N_ATT];
  logic [7:0]       active_reg  [N_ATT];
  logic             powerdown_reg;
  logic             role_reg;
  logic [2:0]       rate_reg;
  logic             osr_reg;
  logic             hpd_reg;
  logic             mpd_reg;
  logic [1:0]       zfs_reg;
  logic             hold_reg;
  logic [1:0]       mute_sync_reg;
  logic [1:0]       fclk_sync_reg;
  logic [1:0]       bclk_sync_reg;
  logic             gen_frame_clock;
  logic             gen_bit_clock;
  logic [5:0]       zfs_sel;
  logic             zero_report;
  logic             mute_request;

  assign wr_sreset  = wr.en && (wr.addr == `CCV_OFS_SOFT_RESET);
  assign wr_regular = wr.en && !wr_sreset;
  assign wr_idx     = atten_index(wr.addr);
  assign wr_update  = wr_regular && (wr_idx != 3'(N_ATT))
                      && wr.data[`CCV_BIT_UPDATE];

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hold_reg <= 1'b0;
    else if (wr_sreset)
      hold_reg <= 1'b1;
    else if (wr_regular)
      hold_reg <= 1'b0;
  end

  // Attenuation latches: one pending and one active word per register.
  generate
    for (genvar i = 0; i < N_ATT; i++)
    begin : g_atten
      always_ff @(posedge clk)
      begin
        if (!rst_n || wr_sreset)
          pending_reg[i] <= `CCV_RST_ATTEN;
        else if (wr_regular && wr_idx == 3'(i))
          pending_reg[i] <= wr.data[7:0];
      end

      // The written word reaches the active set in the same transfer.
      always_ff @(posedge clk)
      begin
        if (!rst_n || wr_sreset)
          active_reg[i] <= `CCV_RST_ATTEN;
        else if (wr_update)
          active_reg[i] <= (wr_idx == 3'(i)) ? wr.data[7:0]
                           : pending_reg[i];
      end
    end
  endgenerate

  // Interface and power register.
  always_ff @(posedge clk)
  begin
    if (!rst_n || wr_sreset)
    begin
      powerdown_reg <= 1'b0;
      role_reg      <= 1'b0;
      rate_reg      <= `CCV_RST_RATE;
    end
    else if (wr_regular && wr.addr == `CCV_OFS_IFACE_PWR)
    begin
      powerdown_reg <= wr.data[`CCV_BIT_POWERDOWN];
      role_reg      <= wr.data[`CCV_BIT_ROLE];
      rate_reg      <= wr.data[`CCV_RATE_MSB:`CCV_RATE_LSB];
    end
  end

  // ADC oversampling register.
  always_ff @(posedge clk)
  begin
    if (!rst_n || wr_sreset)
      osr_reg <= 1'b0;
    else if (wr_regular && wr.addr == `CCV_OFS_ADC_OSR)
      osr_reg <= wr.data[`CCV_BIT_OSR];
  end

  // ADC control register: highpass and mute pin decode.
  always_ff @(posedge clk)
  begin
    if (!rst_n || wr_sreset)
    begin
      hpd_reg <= 1'b0;
      mpd_reg <= 1'b0;
    end
    else if (wr_regular && wr.addr == `CCV_OFS_ADC_CTRL)
    begin
      hpd_reg <= wr.data[`CCV_BIT_HPD];
      mpd_reg <= wr.data[`CCV_BIT_MPD];
    end
  end

  // Zero-flag select register.
  always_ff @(posedge clk)
  begin
    if (!rst_n || wr_sreset)
      zfs_reg <= `CCV_RST_ZFS;
    else if (wr_regular && wr.addr == `CCV_OFS_ZERO_FLAG)
      zfs_reg <= wr.data[`CCV_ZFS_MSB:`CCV_ZFS_LSB];
  end

  // Pin inputs cross into clk through two flops each.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mute_sync_reg <= 2'h0;
      fclk_sync_reg <= 2'h0;
      bclk_sync_reg <= 2'h0;
    end
    else
    begin
      mute_sync_reg <= {mute_sync_reg[0], mute_pin_in};
      fclk_sync_reg <= {fclk_sync_reg[0], frame_clock_in};
      bclk_sync_reg <= {bclk_sync_reg[0], bit_clock_in};
    end
  end

  // The generator stops in slave role, in powerdown and in reset hold.
  ccv_clkgen u_clkgen (
    .clk         (clk),
    .rst_n       (rst_n),
    .run         (role_reg && !powerdown_reg && !hold_reg),
    .rate        (rate_reg),
    .frame_clock (gen_frame_clock),
    .bit_clock   (gen_bit_clock)
  );

  always_comb
  begin
    zfs_sel      = zfs_mask(zfs_reg);
    zero_report  = &(dac_zero_flag | ~zfs_sel);
    mute_request = mute_pin_is_input && mute_sync_reg[1];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frame_clock_out  <= 1'b0;
      bit_clock_out    <= 1'b0;
      frame_clock_oe_n <= 1'b1;
      bit_clock_oe_n   <= 1'b1;
    end
    else
    begin
      frame_clock_out  <= gen_frame_clock;
      bit_clock_out    <= gen_bit_clock;
      frame_clock_oe_n <= !role_reg;
      bit_clock_oe_n   <= !role_reg;
    end
  end

  // In master role the seen clocks follow the driven ones.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frame_clock_seen <= 1'b0;
      bit_clock_seen   <= 1'b0;
    end
    else
    begin
      frame_clock_seen <= role_reg ? gen_frame_clock : fclk_sync_reg[1];
      bit_clock_seen   <= role_reg ? gen_bit_clock : bclk_sync_reg[1];
    end
  end

  // Mute pin direction and reported zero condition.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mute_pin_out  <= 1'b0;
      mute_pin_oe_n <= 1'b1;
    end
    else
    begin
      mute_pin_out  <= zero_report;
      mute_pin_oe_n <= mute_pin_is_input;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      dac_soft_mute <= 6'h00;
    else if (!mute_request)
      dac_soft_mute <= 6'h00;
    else if (mpd_reg)
      dac_soft_mute <= 6'h3F;
    else
      dac_soft_mute <= zfs_sel;
  end

  // Status outputs.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ref_powerdown       <= 1'b0;
      adc_osr_64x         <= 1'b0;
      adc_highpass_bypass <= 1'b0;
      soft_reset_hold     <= 1'b0;
    end
    else
    begin
      ref_powerdown       <= powerdown_reg;
      adc_osr_64x         <= osr_reg && (rate_reg == `CCV_RATE_256 ||
                                         rate_reg == `CCV_RATE_384);
      adc_highpass_bypass <= hpd_reg;
      soft_reset_hold     <= hold_reg;
    end
  end

  // Active attenuation words. Code 00 means full mute downstream.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      atten_active.chan   <= {6{`CCV_RST_ATTEN}};
      atten_active.global <= `CCV_RST_ATTEN;
    end
    else
    begin
      for (int c = 0; c < 6; c++)
        atten_active.chan[c] <= active_reg[c];
      atten_active.global <= active_reg[6];
    end
  end

endmodule : ccv_ctrl

// File: tb/ccv_ctrl_monitor.sv
// Assertion checker bound to the codec control register bank.
`timescale 1ns/100ps
module ccv_ctrl_monitor
  import ccv_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_n,
  input wire ccv_pkg::ccv_wr_t    wr,
  input wire logic                ref_powerdown,
  input wire logic                frame_clock_oe_n,
  input wire logic                bit_clock_oe_n,
  input wire logic                adc_osr_64x,
  input wire logic                adc_highpass_bypass,
  input wire ccv_pkg::ccv_atten_t atten_active,
  input wire logic                soft_reset_hold
);
  logic att_wr;
  logic chg_reg;

  assign att_wr = wr.en && (wr.addr inside {[7'h00:7'h01], [7'h04:7'h08]});

  // Remembers a write that may still be moving the active words outward.
  always_ff @(posedge clk)
    chg_reg <= !rst_n || (wr.en && (wr.addr == 7'h1F || wr.data[8]));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pwr;
    wr.en && wr.addr == 7'h0A |-> ##2 ref_powerdown == $past(wr.data[4], 2);
  endproperty
  a_pwr: assert property (p_pwr) else $error("powerdown wrong");
  property p_role;
    wr.en && wr.addr == 7'h0A |-> ##2
      frame_clock_oe_n == !$past(wr.data[5], 2) &&
      bit_clock_oe_n == frame_clock_oe_n;
  endproperty
  a_role: assert property (p_role) else $error("role wrong");
  property p_osr;
    wr.en && wr.addr == 7'h0B && !wr.data[8] |-> ##2 !adc_osr_64x;
  endproperty
  a_osr: assert property (p_osr) else $error("osr set");
  property p_osr_rate;
    wr.en && wr.addr == 7'h0A && !(wr.data[8:6] inside {3'h2, 3'h3})
      |-> ##2 !adc_osr_64x;
  endproperty
  a_osr_rate: assert property (p_osr_rate) else $error("osr rate");
  property p_hpd;
    wr.en && wr.addr == 7'h0C |-> ##2
      adc_highpass_bypass == $past(wr.data[3], 2);
  endproperty
  a_hpd: assert property (p_hpd) else $error("highpass wrong");
  property p_hold_att;
    att_wr && !wr.data[8] && !chg_reg |=> ##1 $stable(atten_active);
  endproperty
  a_hold_att: assert property (p_hold_att) else $error("early");
  property p_upd;
    att_wr && wr.addr == 7'h08 && wr.data[8] |-> ##2
      atten_active.global == $past(wr.data[7:0], 2);
  endproperty
  a_upd: assert property (p_upd) else $error("update wrong");
  property p_sreset;
    wr.en && wr.addr == 7'h1F |-> ##2 !ref_powerdown && frame_clock_oe_n
      && atten_active.chan[2] == 8'hFF;
  endproperty
  a_sreset: assert property (p_sreset) else $error("no reset");
  property p_hold_set;
    wr.en && wr.addr == 7'h1F ##1 !wr.en |-> ##1 soft_reset_hold;
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("no hold");
  property p_hold_clr;
    wr.en && wr.addr != 7'h1F ##1 !(wr.en && wr.addr == 7'h1F)
      |-> ##1 !soft_reset_hold;
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("hold stuck");
endmodule : ccv_ctrl_monitor

bind ccv_ctrl ccv_ctrl_monitor u_ccv_ctrl_monitor (
  .clk(clk), .rst_n(rst_n), .wr(wr), .ref_powerdown(ref_powerdown),
  .frame_clock_oe_n(frame_clock_oe_n), .bit_clock_oe_n(bit_clock_oe_n),
  .adc_osr_64x(adc_osr_64x), .adc_highpass_bypass(adc_highpass_bypass),
  .atten_active(atten_active), .soft_reset_hold(soft_reset_hold)
);

// File: tb/ccv_host.sv
// Host controller model issuing control register writes.
`timescale 1ns/100ps
module ccv_host
  import ccv_pkg::*;
(
  input  wire logic       clk,
  output ccv_pkg::ccv_wr_t wr
);
  initial wr = '0;

  task automatic put(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk);
    wr <= {1'b1, a, d};
    @(negedge clk);
    // Idle lines carry the inverse so a stale word is never mistaken.
    wr <= {1'b0, ~a, ~d};
  endtask : put

  // Converters go down first so the whole part ends fully powered down.
  task automatic full_powerdown(input logic [2:0] rate);
    put(7'h0A, {rate, 2'b00, 4'hF});
    put(7'h0A, {rate, 2'b01, 4'hF});
  endtask : full_powerdown

  task automatic set_96k;
    put(7'h0B, 9'h100);
  endtask : set_96k
endmodule : ccv_host

// File: tb/testbench.sv
// Self-checking testbench for the codec control register bank.
`timescale 1ns/100ps
module testbench;
  import ccv_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  ccv_wr_t    wr;
  logic       mute_pin_is_input = 1'b1;
  logic [5:0] dac_zero_flag = 6'h00;
  logic       mute_pin_in = 1'b0;
  logic       frame_clock_in = 1'b0;
  logic       bit_clock_in = 1'b0;
  logic       bit_clock_seen;
  logic       mute_pin_out, mute_pin_oe_n, frame_clock_out, frame_clock_oe_n;
  logic       bit_clock_out, bit_clock_oe_n, frame_clock_seen, ref_powerdown;
  logic       adc_osr_64x, adc_highpass_bypass, soft_reset_hold;
  logic [5:0] dac_soft_mute;
  ccv_atten_t atten_active;
  int         mismatches = 0;
  int         total_checks = 0;

  always #2 clk = ~clk;

  ccv_host u_ccv_host (.clk(clk), .wr(wr));
  ccv_ctrl u_ccv_ctrl (
    .clk(clk), .rst_n(rst_n), .wr(wr), .mute_pin_is_input(mute_pin_is_input),
    .dac_zero_flag(dac_zero_flag), .mute_pin_in(mute_pin_in),
    .mute_pin_out(mute_pin_out), .mute_pin_oe_n(mute_pin_oe_n),
    .frame_clock_in(frame_clock_in), .frame_clock_out(frame_clock_out),
    .frame_clock_oe_n(frame_clock_oe_n), .bit_clock_in(bit_clock_in),
    .bit_clock_out(bit_clock_out), .bit_clock_oe_n(bit_clock_oe_n),
    .frame_clock_seen(frame_clock_seen), .bit_clock_seen(bit_clock_seen),
    .ref_powerdown(ref_powerdown), .adc_osr_64x(adc_osr_64x),
    .adc_highpass_bypass(adc_highpass_bypass),
    .dac_soft_mute(dac_soft_mute), .atten_active(atten_active),
    .soft_reset_hold(soft_reset_hold)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Outputs lag the register by one edge, so two edges are let pass.
  task automatic w(input logic [6:0] a, input logic [8:0] d);
    u_ccv_host.put(a, d);
    repeat (2) @(negedge clk);
  endtask : w

  task automatic frame_period(output int per, output int bits);
    int c, n, t0;
    logic pf, pb;
    c = 0; n = 0; t0 = 0; per = -1; bits = 0;
    pf = frame_clock_out; pb = bit_clock_out;
    while (per < 0 && c < 3000)
    begin
      @(negedge clk);
      c++;
      if (!pf && frame_clock_out)
      begin
        n++;
        if (n == 2) t0 = c;
        if (n == 3) per = c - t0;
      end
      if (n >= 2 && c > t0 && !pb && bit_clock_out) bits++;
      pf = frame_clock_out; pb = bit_clock_out;
    end
    if (per < 0)
    begin
      mismatches++;
      end_sim;
    end
  endtask : frame_period

  task automatic t_atten;
    chk(atten_active, {7{8'hFF}});
    w(7'h00, 9'h000);
    w(7'h01, 9'h0FE);
    w(7'h02, 9'h1FF);
    chk(atten_active, {7{8'hFF}});
    w(7'h08, 9'h101);
    chk(atten_active, {32'hFFFFFFFF, 8'hFE, 8'h00, 8'h01});
    w(7'h04, 9'h033);
    chk(atten_active, {32'hFFFFFFFF, 8'hFE, 8'h00, 8'h01});
    w(7'h07, 9'h1AA);
    chk(atten_active, {8'hAA, 16'hFFFF, 8'h33, 24'hFE0001});
  endtask : t_atten

  task automatic t_iface;
    chk({ref_powerdown, frame_clock_oe_n}, 2'b01);
    u_ccv_host.full_powerdown(3'h2);
    repeat (2) @(negedge clk);
    chk(ref_powerdown, 1'b1);
    w(7'h0A, 9'h080);
    chk(ref_powerdown, 1'b0);
    // Opposite levels on the two pins show that neither path is crossed.
    frame_clock_in = 1'b1;
    bit_clock_in = 1'b0;
    repeat (4) @(negedge clk);
    chk({frame_clock_oe_n, bit_clock_oe_n, frame_clock_seen, bit_clock_seen},
        4'hE);
    frame_clock_in = 1'b0;
    bit_clock_in = 1'b1;
    repeat (4) @(negedge clk);
    chk({frame_clock_oe_n, bit_clock_oe_n, frame_clock_seen, bit_clock_seen},
        4'hD);
    bit_clock_in = 1'b0;
  endtask : t_iface

  task automatic t_rates;
    int per, bits;
    int ratio [6] = '{128, 192, 256, 384, 512, 768};
    for (int k = 0; k < 6; k++)
    begin
      w(7'h0A, {k[2:0], 6'h20});
      chk({frame_clock_oe_n, bit_clock_oe_n}, 2'b00);
      frame_period(per, bits);
      chk(per, ratio[k]);
      chk(bits, 64);
      // In master role the clocks seen inside are the ones driven out.
      chk({frame_clock_seen, bit_clock_seen},
          {frame_clock_out, bit_clock_out});
    end
  endtask : t_rates

  task automatic t_osr;
    chk(adc_osr_64x, 1'b0);
    u_ccv_host.set_96k;
    for (int k = 4; k < 12; k++)
    begin
      w(7'h0A, {k[2:0], 6'h00});
      chk(adc_osr_64x, k[2:0] inside {3'h2, 3'h3});
    end
    w(7'h0B, 9'h000);
    chk(adc_osr_64x, 1'b0);
  endtask : t_osr

  task automatic t_mute;
    logic [5:0] m [4] = '{6'h3F, 6'h03, 6'h0C, 6'h30};
    mute_pin_in = 1'b1;
    for (int z = 0; z < 4; z++)
    begin
      w(7'h09, {6'h00, z[1:0], 1'b0});
      repeat (2) @(negedge clk);
      chk(dac_soft_mute, m[z]);
      mute_pin_is_input = 1'b0;
      dac_zero_flag = m[z];
      repeat (2) @(negedge clk);
      chk({mute_pin_oe_n, mute_pin_out}, 2'b01);
      dac_zero_flag = m[z] & (m[z] - 6'h01);
      repeat (2) @(negedge clk);
      chk(mute_pin_out, 1'b0);
      mute_pin_is_input = 1'b1;
    end
    w(7'h0C, 9'h040);
    chk(dac_soft_mute, 6'h3F);
    mute_pin_in = 1'b0;
    repeat (4) @(negedge clk);
    chk(dac_soft_mute, 6'h00);
  endtask : t_mute

  task automatic t_soft;
    w(7'h0C, 9'h048);
    w(7'h0A, 9'h0B0);
    w(7'h1F, 9'h000);
    chk({soft_reset_hold, ref_powerdown, frame_clock_oe_n}, 3'h5);
    chk({adc_highpass_bypass, atten_active}, {1'b0, {7{8'hFF}}});
    w(7'h0C, 9'h008);
    chk({soft_reset_hold, adc_highpass_bypass}, 2'b01);
  endtask : t_soft

  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_atten;
    t_iface;
    t_rates;
    t_osr;
    t_mute;
    t_soft;
    end_sim;
  end
endmodule : testbench
